/* File: hw/sse_cmd_top.sv */
// Command interpreter of a two-channel serial encoder receiver, sitting behind
// a byte-wide parameter channel and data channel of the carrier. Assumes the
// host byte strobes are on clk_sys_i; encoder data pins are asynchronous.
// Behaviour
// - Per-channel bridges fix binary or Gray coding and the low or high rate.
// - After selection, data channel takes one-byte read and two-byte mode commands.
// - Read command 1 acquires the addressed encoder's position and returns it.
// - Value returns least significant byte first, D7..D0 in bits 7..0.
// - Status zero when value obtained, one when encoder sent no data.
// - Each read drives 25 clock pulses and shifts serial bits in.
// - At most 24 bits captured; surplus trailing bits are dropped.
// - Mode bits 0..4 give length 1..24, default 24; bits 5..7 zero.
// - Block bit 3 of first mode byte applies mode to all encoders.
`include "sse_cfg.svh"
`default_nettype none
module sse_cmd_top #(
  parameter logic [3:0] CHAN_NUM = 4'h1
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       param_valid_i,
  input  wire logic [7:0] param_byte_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_byte_i,
  output logic            cmd_ready_o,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_byte_o,
  input  wire logic       rsp_ready_i,
  output logic            read_error_status_o,
  output logic            func_enabled_o,
  input  wire logic       channel1_coding_bridge_i,
  input  wire logic       channel2_coding_bridge_i,
  input  wire logic       channel1_rate_bridge_i,
  input  wire logic       channel2_rate_bridge_i,
  output logic [1:0]      ssi_clk_o,
  input  wire logic [1:0] ssi_data_i
);
  sse_pkg::sse_top_s s_reg, s_next;
  logic [1:0]            rx_done;
  logic [1:0]            rx_err;
  logic [1:0]            rx_busy;
  logic [`SSE_VAL_W-1:0] rx_value [2];
  logic [1:0]            gray_sel;
  logic [1:0]            rate_sel;
  logic [`SSE_LEN_W-1:0] len_sel [2];
  logic                  cmd_take;
  logic [2:0]            cmd_code;
  logic                  mode_ok;

  ////////////////////////////////////////////////////////////////////////////
  // bridges steer each receiver
  assign gray_sel   = {channel2_coding_bridge_i, channel1_coding_bridge_i};
  assign rate_sel   = {channel2_rate_bridge_i, channel1_rate_bridge_i};
  assign len_sel[0] = s_reg.len0;
  assign len_sel[1] = s_reg.len1;

  genvar ci;
  generate
    for (ci = 0; ci < 2; ci++) begin : g_rx
      sse_ssi_rx u_rx (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .start_i   (s_reg.rd_start[ci]),
        .rate_hi_i (rate_sel[ci]),
        .gray_i    (gray_sel[ci]),
        .len_i     (len_sel[ci]),
        .data_i    (ssi_data_i[ci]),
        .ssi_clk_o (ssi_clk_o[ci]),
        .busy_o    (rx_busy[ci]),
        .done_o    (rx_done[ci]),
        .value_o   (rx_value[ci]),
        .err_o     (rx_err[ci])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  assign cmd_ready_o = (s_reg.state == sse_pkg::SSE_IDLE) || (s_reg.state == sse_pkg::SSE_MODE);
  assign cmd_take    = cmd_valid_i && cmd_ready_o;
  assign cmd_code    = cmd_byte_i[`SSE_CMD_MSB:`SSE_CMD_LSB];
  assign mode_ok     = cmd_byte_i[`SSE_MODE_RSV_MSB:`SSE_MODE_RSV_LSB] == 3'h0 &&
                       cmd_byte_i[`SSE_LEN_W-1:0] != 5'h0 &&
                       cmd_byte_i[`SSE_LEN_W-1:0] <= `SSE_LEN_MAX;

  always_comb begin
    s_next          = s_reg;
    s_next.rd_start = 2'b00;
    if (param_valid_i) begin
      if (!s_reg.parm_second) begin
        // Command number in the upper nibble, channel in the lower one
        s_next.parm_second = (param_byte_i == {`SSE_PCMD_FUNC, CHAN_NUM});
      end else begin
        s_next.parm_second = 1'b0;
        s_next.func_en     = (param_byte_i == `SSE_PROCEDURE_SELECTOR_CODE);
      end
    end
    case (s_reg.state)
      sse_pkg::SSE_IDLE: begin
        if (cmd_take && s_reg.func_en) begin
          s_next.sel = cmd_byte_i[`SSE_ENC_BIT];
          if (cmd_code == `SSE_DCMD_READ) begin
            s_next.rd_start[cmd_byte_i[`SSE_ENC_BIT]] = 1'b1;
            s_next.state = sse_pkg::SSE_WAIT;
          end else if (cmd_code == `SSE_DCMD_MODE) begin
            s_next.block = cmd_byte_i[`SSE_BLOCK_BIT];
            s_next.state = sse_pkg::SSE_MODE;
          end
        end
      end
      sse_pkg::SSE_MODE: begin
        if (cmd_take) begin
          s_next.state = sse_pkg::SSE_IDLE;
          if (mode_ok) begin
            if (s_reg.block || !s_reg.sel) begin
              s_next.len0 = cmd_byte_i[`SSE_LEN_W-1:0];
            end
            if (s_reg.block || s_reg.sel) begin
              s_next.len1 = cmd_byte_i[`SSE_LEN_W-1:0];
            end
          end
        end
      end
      sse_pkg::SSE_WAIT: begin
        if (rx_done[s_reg.sel]) begin
          s_next.shreg    = {8'h00, rx_value[s_reg.sel]};
          s_next.err      = rx_err[s_reg.sel];
          s_next.byte_cnt = `SSE_RSP_BYTES;
          s_next.state    = sse_pkg::SSE_SEND;
        end
      end
      sse_pkg::SSE_SEND: begin
        if (rsp_ready_i) begin
          s_next.shreg    = {8'h00, s_reg.shreg[`SSE_RSP_W-1:8]};
          s_next.byte_cnt = s_reg.byte_cnt - 3'h1;
          if (s_reg.byte_cnt == 3'h1) begin
            s_next.state = sse_pkg::SSE_IDLE;
          end
        end
      end
      default: begin
        s_next.state = sse_pkg::SSE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg      <= '0;
      s_reg.len0 <= `SSE_LEN_DEF;
      s_reg.len1 <= `SSE_LEN_DEF;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rsp_valid_o         = (s_reg.state == sse_pkg::SSE_SEND);
  assign rsp_byte_o          = s_reg.shreg[7:0];
  assign read_error_status_o = s_reg.err;
  assign func_enabled_o      = s_reg.func_en;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_NO_CMD_UNSELECTED: assert property (cmd_take && !s_reg.func_en && s_reg.state == sse_pkg::SSE_IDLE
                                          |=> s_reg.state == sse_pkg::SSE_IDLE)
    else $error("Command acted on before function selection");
  AST_READ_STARTS_RX: assert property (cmd_take && s_reg.func_en && s_reg.state == sse_pkg::SSE_IDLE &&
                                       cmd_code == `SSE_DCMD_READ
                                       |=> s_reg.rd_start == (2'b01 << s_reg.sel) ##1 rx_busy[s_reg.sel])
    else $error("Read command did not start the addressed receiver");
  AST_FIRST_BYTE: assert property ($rose(rsp_valid_o) |-> rsp_byte_o == rx_value[s_reg.sel][7:0])
    else $error("First returned byte is not the low byte");
  AST_TOP_BYTE_ZERO: assert property (rsp_valid_o && s_reg.byte_cnt == 3'h1 |-> rsp_byte_o == 8'h00)
    else $error("Bits above the captured width are not zero");
  AST_STATUS: assert property ($rose(rsp_valid_o) |-> read_error_status_o == rx_err[s_reg.sel])
    else $error("Status does not match the receiver outcome");
  AST_LEN_LEGAL: assert property (s_reg.len0 != 5'h0 && s_reg.len0 <= `SSE_LEN_MAX &&
                                  s_reg.len1 != 5'h0 && s_reg.len1 <= `SSE_LEN_MAX)
    else $error("Telegram length left its legal range");
  AST_FUNC_SELECT: assert property (param_valid_i && s_reg.parm_second && param_byte_i == `SSE_PROCEDURE_SELECTOR_CODE
                                    |=> func_enabled_o)
    else $error("Procedure code did not enable reception");
  AST_BLOCK_MODE: assert property (cmd_take && s_reg.state == sse_pkg::SSE_MODE && s_reg.block && mode_ok
                                   |=> s_reg.len0 == s_reg.len1)
    else $error("Block mode did not reach every encoder");

  COV_READ_SENT: cover property (rsp_valid_o && rsp_ready_i && s_reg.byte_cnt == 3'h1);
  COV_BLOCK_MODE: cover property (cmd_take && s_reg.state == sse_pkg::SSE_MODE && s_reg.block);
  COV_READ_ERROR: cover property ($rose(rsp_valid_o) && read_error_status_o);
endmodule : sse_cmd_top
`default_nettype wire

/* File: hw/sse_cfg.svh */
// Constants of the serial encoder command interface.
// Assumes the system clock rate below; both link half-period counts derive from it.
`ifndef SSE_CFG_SVH
`define SSE_CFG_SVH
`define SSE_CLK_HZ      125000000
`define SSE_RATE_LO_BPS 150000
`define SSE_RATE_HI_BPS 300000
`define SSE_HALF_LO     (`SSE_CLK_HZ / (2 * `SSE_RATE_LO_BPS))
`define SSE_HALF_HI     (`SSE_CLK_HZ / (2 * `SSE_RATE_HI_BPS))
`define SSE_DIV_W       10
`define SSE_VAL_W       24
`define SSE_RSP_W       32
`define SSE_LEN_W       5
`define SSE_LEN_DEF     5'h18
`define SSE_LEN_MAX     5'h18
`define SSE_PULSES      5'h19
`define SSE_PCMD_FUNC   4'h5
`define SSE_PROCEDURE_SELECTOR_CODE   8'h0C
`define SSE_DCMD_READ   3'h1
`define SSE_DCMD_MODE   3'h3
`define SSE_CMD_LSB     0
`define SSE_CMD_MSB     2
`define SSE_BLOCK_BIT   3
`define SSE_ENC_BIT     4
`define SSE_MODE_RSV_MSB 7
`define SSE_MODE_RSV_LSB 5
`define SSE_RSP_BYTES   3'h4
`endif

/* File: hw/sse_pkg.sv */
// Types shared by the encoder command interface and its link receivers.
// Assumes sse_cfg.svh for the divider, length, value and response widths.
`include "sse_cfg.svh"
`default_nettype none
package sse_pkg;
  typedef enum logic [1:0] {
    SSE_IDLE = 2'b00,
    SSE_WAIT = 2'b01,
    SSE_SEND = 2'b11,
    SSE_MODE = 2'b10
  } sse_state_e;

  typedef struct packed {
    logic                     sync1;
    logic                     sync2;
    logic                     busy;
    logic                     fin;
    logic                     clk_out;
    logic [`SSE_DIV_W-1:0]    div;
    logic [`SSE_LEN_W-1:0]    pulses;
    logic [`SSE_LEN_W-1:0]    bits_left;
    logic [`SSE_VAL_W-1:0]    shreg;
    logic                     all_high;
    logic                     done;
    logic [`SSE_VAL_W-1:0]    value;
    logic                     err;
  } sse_rx_s;

  typedef struct packed {
    logic                     func_en;
    logic                     parm_second;
    sse_state_e               state;
    logic                     sel;
    logic                     block;
    logic [`SSE_LEN_W-1:0]    len0;
    logic [`SSE_LEN_W-1:0]    len1;
    logic [1:0]               rd_start;
    logic [`SSE_RSP_W-1:0]    shreg;
    logic [2:0]               byte_cnt;
    logic                     err;
  } sse_top_s;
endpackage : sse_pkg
`default_nettype wire

/* File: hw/sse_ssi_rx.sv */
// One synchronous serial encoder receiver: makes the link clock by division
// and shifts in the telegram. Assumes the encoder data pin is asynchronous.
`include "sse_cfg.svh"
`default_nettype none
module sse_ssi_rx (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic                  start_i,
  input  wire logic                  rate_hi_i,
  input  wire logic                  gray_i,
  input  wire logic [`SSE_LEN_W-1:0] len_i,
  input  wire logic                  data_i,
  output logic                       ssi_clk_o,
  output logic                       busy_o,
  output logic                       done_o,
  output logic [`SSE_VAL_W-1:0]      value_o,
  output logic                       err_o
);
  sse_pkg::sse_rx_s s_reg, s_next;
  logic [`SSE_VAL_W-1:0] bin;
  logic [`SSE_DIV_W-1:0] half;

  assign half = rate_hi_i ? `SSE_DIV_W'(`SSE_HALF_HI) : `SSE_DIV_W'(`SSE_HALF_LO);

  ////////////////////////////////////////////////////////////////////////////
  // gray to binary
  genvar gi;
  generate
    for (gi = 0; gi < `SSE_VAL_W; gi++) begin : g_bin
      assign bin[gi] = ^s_reg.shreg[`SSE_VAL_W-1:gi];
    end
  endgenerate

  always_comb begin
    s_next       = s_reg;
    s_next.sync1 = data_i;
    s_next.sync2 = s_reg.sync1;
    s_next.done  = 1'b0;
    if (s_reg.fin) begin
      s_next.fin   = 1'b0;
      s_next.busy  = 1'b0;
      s_next.done  = 1'b1;
      s_next.value = gray_i ? bin : s_reg.shreg;
      s_next.err   = s_reg.all_high;
    end else if (s_reg.busy) begin
      if (s_reg.div == `SSE_DIV_W'(1)) begin
        s_next.div     = half;
        s_next.clk_out = ~s_reg.clk_out;
        if (!s_reg.clk_out) begin
          s_next.pulses = s_reg.pulses + 5'h1;
          if (s_reg.pulses != 5'h0 && s_reg.bits_left != 5'h0) begin
            s_next.shreg     = {s_reg.shreg[`SSE_VAL_W-2:0], s_reg.sync2};
            s_next.bits_left = s_reg.bits_left - 5'h1;
            s_next.all_high  = s_reg.all_high & s_reg.sync2;
          end
          if (s_reg.pulses + 5'h1 == `SSE_PULSES) begin
            s_next.fin = 1'b1;
          end
        end
      end else begin
        s_next.div = s_reg.div - `SSE_DIV_W'(1);
      end
    end else if (start_i) begin
      s_next.busy      = 1'b1;
      s_next.div       = half;
      s_next.pulses    = 5'h0;
      s_next.bits_left = len_i;
      s_next.shreg     = '0;
      s_next.all_high  = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg         <= '0;
      s_reg.clk_out <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ssi_clk_o = s_reg.clk_out;
  assign busy_o    = s_reg.busy;
  assign done_o    = s_reg.done;
  assign value_o   = s_reg.value;
  assign err_o     = s_reg.err;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_PULSE_COUNT: assert property (s_reg.fin |-> s_reg.pulses == `SSE_PULSES)
    else $error("Telegram ended with wrong pulse count");
  AST_CLK_IDLE_HIGH: assert property (!s_reg.busy |-> ssi_clk_o)
    else $error("Link clock low while idle");
  AST_UPPER_ZERO: assert property (done_o && len_i < `SSE_LEN_MAX |-> (value_o >> len_i) == '0)
    else $error("Captured value wider than telegram length");
  AST_BINARY_PASS: assert property (done_o && !gray_i |-> value_o == $past(s_reg.shreg))
    else $error("Binary coding altered the value");
  COV_RX_DONE: cover property (done_o && !err_o);
endmodule : sse_ssi_rx
`default_nettype wire

/* File: sim/sse_enc_model.sv */
// Behavioural serial encoder for one link channel of the interface.
// Assumes the link clock idles high and each frame has 25 falling edges.
`default_nettype none
module sse_enc_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        present_i,
  input  wire logic [24:0] value_i,
  input  wire logic [4:0]  len_i,
  output logic             data_o
);
  timeunit 1ns;
  timeprecision 1ps;

  int n;

  ////////////////////////////////////////////////////////////////////////////
  // Frame position by falling edge, back to idle after the last rising edge
  always @(negedge clk_i or posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      n = 0;
    end else if (!clk_i) begin
      n = n + 1;
    end else if (n >= 25) begin
      n = 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // long telegrams: the tail bit is never clocked out
  // Absent encoder leaves the line at its pulled-up level
  always_comb begin
    if (!present_i || n == 0) begin
      data_o = 1'h1;
    end else if (n == 1 || n > len_i + 1) begin
      data_o = 1'h0;
    end else begin
      data_o = value_i[len_i + 1 - n];
    end
  end
endmodule : sse_enc_model
`default_nettype wire

/* File: sim/sse_cmd_top_tb_top.sv */
// Self-checking bench of the encoder command interface.
// Assumes two behavioural encoders on the link pins and host byte strobes.
`default_nettype none
module sse_cmd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys_i     = 1'h0;
  logic        rst_i         = 1'h1;
  logic        param_valid_i = 1'h0;
  logic [7:0]  param_byte_i  = 8'h00;
  logic        cmd_valid_i   = 1'h0;
  logic [7:0]  cmd_byte_i    = 8'h00;
  logic        rsp_ready_i   = 1'h0;
  logic        cb1           = 1'h0;
  logic        cb2           = 1'h1;
  logic        rb1           = 1'h1;
  logic        rb2           = 1'h1;
  logic [1:0]  pres          = 2'h3;
  logic [24:0] val1          = 25'h0000000;
  logic [24:0] val2          = 25'h0000000;
  logic [4:0]  len1          = 5'h18;
  logic [4:0]  len2          = 5'h18;
  logic        cmd_ready_o;
  logic        rsp_valid_o;
  logic [7:0]  rsp_byte_o;
  logic        err_st;
  logic        func_en;
  logic [1:0]  ssi_clk;
  logic [1:0]  ssi_data;
  int          errors        = 0;
  int          tests_run     = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  sse_cmd_top #(.CHAN_NUM(4'h1)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .param_valid_i(param_valid_i), .param_byte_i(param_byte_i),
    .cmd_valid_i(cmd_valid_i), .cmd_byte_i(cmd_byte_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_byte_o(rsp_byte_o), .rsp_ready_i(rsp_ready_i),
    .read_error_status_o(err_st), .func_enabled_o(func_en),
    .channel1_coding_bridge_i(cb1), .channel2_coding_bridge_i(cb2),
    .channel1_rate_bridge_i(rb1), .channel2_rate_bridge_i(rb2),
    .ssi_clk_o(ssi_clk), .ssi_data_i(ssi_data));

  sse_enc_model i_enc1 (.clk_i(ssi_clk[0]), .rst_i(rst_i), .present_i(pres[0]), .value_i(val1),
    .len_i(len1), .data_o(ssi_data[0]));
  sse_enc_model i_enc2 (.clk_i(ssi_clk[1]), .rst_i(rst_i), .present_i(pres[1]), .value_i(val2),
    .len_i(len2), .data_o(ssi_data[1]));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask : tick

  task automatic test_done;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Both parameter bytes back to back, strobe held across them
  task automatic param_pair(input logic [7:0] b1, input logic [7:0] b2);
    param_valid_i = 1'h1;
    param_byte_i = b1;
    tick;
    param_byte_i = b2;
    tick;
    param_valid_i = 1'h0;
    tick;
  endtask : param_pair

  // Byte held until taken; valid stays up for a following byte
  task automatic cmd_wr(input logic [7:0] b);
    cmd_byte_i = b;
    cmd_valid_i = 1'h1;
    for (int i = 0; i < 100 && cmd_ready_o !== 1'h1; i++) begin
      tick;
    end
    if (cmd_ready_o !== 1'h1) begin
      chk(1'h0, 1'h1, "command not taken");
      test_done;
    end
    tick;
  endtask : cmd_wr

  task automatic mode(input logic sel, input logic blk, input logic [7:0] arg);
    cmd_wr({3'h0, sel, blk, 3'h3});
    cmd_wr(arg);
    cmd_valid_i = 1'h0;
    tick;
  endtask : mode

  task automatic rd(input logic sel, input logic [31:0] exp, input logic exp_err, input logic vchk);
    logic [31:0] got;
    logic        prev;
    int          falls;
    got = 32'h00000000;
    prev = 1'h1;
    falls = 0;
    cmd_wr({3'h0, sel, 4'h1});
    cmd_valid_i = 1'h0;
    for (int i = 0; i < 30000 && rsp_valid_o !== 1'h1; i++) begin
      if (prev && !ssi_clk[sel]) begin
        falls++;
      end
      prev = ssi_clk[sel];
      tick;
    end
    if (rsp_valid_o !== 1'h1) begin
      chk(1'h0, 1'h1, "no response");
      test_done;
    end
    chk(falls, 25, "link pulses");
    chk(ssi_clk[sel], 1'h1, "link clock idle");
    chk(err_st, exp_err, "status");
    rsp_ready_i = 1'h1;
    for (int b = 0; b < 4; b++) begin
      got[8*b +: 8] = rsp_byte_o;
      tick;
    end
    rsp_ready_i = 1'h0;
    if (vchk) begin
      chk(got, exp, "value bytes");
    end
    chk(rsp_valid_o, 1'h0, "response over");
    chk(cmd_ready_o, 1'h1, "ready again");
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1;
    rst_i = 1'h0;
    tick;
    cmd_wr(8'h01);
    cmd_valid_i = 1'h0;
    repeat (100) tick;
    chk(rsp_valid_o, 1'h0, "read before enable");
    chk(ssi_clk, 2'h3, "clocks idle");
    param_pair(8'h52, 8'h0C);
    chk(func_en, 1'h0, "foreign channel");
    param_pair(8'h51, 8'h0C);
    chk(func_en, 1'h1, "function on");
    mode(1'h0, 1'h0, 8'h20);
    len1 = 5'h19;
    val1 = 25'h15AC3E7;
    rd(1'h0, 32'h00AD61F3, 1'h0, 1'h1);
    mode(1'h1, 1'h0, 8'h10);
    len2 = 5'h10;
    val2 = 25'h000E198;
    rd(1'h1, 32'h0000BEEF, 1'h0, 1'h1);
    mode(1'h0, 1'h1, 8'h08);
    pres = 2'h2;
    rd(1'h0, 32'h00000000, 1'h1, 1'h0);
    rb2 = 1'h0;
    len2 = 5'h08;
    val2 = 25'h0000077;
    rd(1'h1, 32'h0000005A, 1'h0, 1'h1);
    test_done;
  end
endmodule : sse_cmd_top_tb_top
`default_nettype wire
